// ---- src/cpu_regs_pkg.sv ----
// constants and types shared by the cpu register set
package cpu_regs_pkg;

	// condition_flags bit positions
	localparam int FLAG_I = 7;
	localparam int FLAG_U1 = 6;
	localparam int FLAG_H = 5;
	localparam int FLAG_U0 = 4;
	localparam int FLAG_N = 3;
	localparam int FLAG_Z = 2;
	localparam int FLAG_V = 1;
	localparam int FLAG_C = 0;

	// reset values
	localparam logic FLAG_I_RESET = 1'b1;
	localparam logic [14:0] PC_WORD_RESET = 15'h0000;
	localparam logic [15:0] RESET_VECTOR_ADDR = 16'h0000;

	// the eighth word register doubles as the stack pointer
	localparam logic [2:0] SP_IDX = 3'h7;

	// carry positions for half-carry and carry, byte and word
	localparam int HC_BIT_BYTE = 3;
	localparam int HC_BIT_WORD = 11;
	localparam int MSB_BYTE = 7;
	localparam int MSB_WORD = 15;

	typedef enum logic [2:0] {
		ALU_ADD,
		ALU_SUB,
		ALU_NEG,
		ALU_LOGIC,
		ALU_SHIFT
	} alu_kind_t;

	typedef enum logic [1:0] {
		FOP_LOAD,
		FOP_AND,
		FOP_OR,
		FOP_XOR
	} flag_op_t;

	typedef enum logic [3:0] {
		COND_ALWAYS, COND_NEVER, COND_HI, COND_LS,
		COND_CC, COND_CS, COND_NE, COND_EQ,
		COND_VC, COND_VS, COND_PL, COND_MI,
		COND_GE, COND_LT, COND_GT, COND_LE
	} branch_cond_t;

endpackage : cpu_regs_pkg

// ---- src/gpr_bank.sv ----
`timescale 1ns/1ps
// sixteen byte registers pairing into eight word registers
module gpr_bank
	import cpu_regs_pkg::*;
(
	input wire logic core_clk, // cpu clock
	input wire logic nrst, // reset, quiets the checks only
	input wire logic wr_en, // write strobe
	input wire logic wr_word, // 1 word write, 0 byte write
	input wire logic [3:0] wr_idx, // [2:0] register, [3] lower byte
	input wire logic [15:0] wr_data, // byte writes use [7:0]
	input wire logic [2:0] word_a_idx, // word data read select
	output logic [15:0] word_a, // word data read value
	input wire logic [3:0] byte_idx, // byte read select, [3] lower
	output logic [7:0] byte_val, // byte read value
	input wire logic [2:0] addr_idx, // address read select
	output logic [15:0] addr_word, // full word for addressing
	output logic [15:0] stack_pointer // eighth word register
);
	logic [7:0] gpr_upper_byte [8];
	logic [7:0] gpr_lower_byte [8];

	genvar g;
	generate
		for (g = 0; g < 8; g++) begin : g_reg
			// no reset: contents are undefined until written
			always_ff @(posedge core_clk) begin
				if (wr_en && wr_idx[2:0] == 3'(g) && (wr_word || !wr_idx[3]))
					gpr_upper_byte[g] <= wr_word ? wr_data[15:8] : wr_data[7:0];
			end
			always_ff @(posedge core_clk) begin
				if (wr_en && wr_idx[2:0] == 3'(g) && (wr_word || wr_idx[3]))
					gpr_lower_byte[g] <= wr_data[7:0];
			end
		end
	endgenerate

	assign word_a = {gpr_upper_byte[word_a_idx],
		gpr_lower_byte[word_a_idx]};
	assign byte_val = byte_idx[3] ? gpr_lower_byte[byte_idx[2:0]]
		: gpr_upper_byte[byte_idx[2:0]];
	assign addr_word = {gpr_upper_byte[addr_idx],
		gpr_lower_byte[addr_idx]};
	assign stack_pointer = {gpr_upper_byte[SP_IDX],
		gpr_lower_byte[SP_IDX]};

	property p_word_write;
		@(posedge core_clk) disable iff (!nrst)
		(wr_en && wr_word) |=> {gpr_upper_byte[$past(wr_idx[2:0])],
			gpr_lower_byte[$past(wr_idx[2:0])]} == $past(wr_data);
	endproperty
	a_word_write: assert property (p_word_write)
		else $error("word write lost");

	property p_byte_keep;
		@(posedge core_clk) disable iff (!nrst)
		(wr_en && !wr_word && !wr_idx[3]) |=>
			gpr_lower_byte[$past(wr_idx[2:0])] ==
			$past(gpr_lower_byte[wr_idx[2:0]]) &&
			gpr_upper_byte[$past(wr_idx[2:0])] == $past(wr_data[7:0]);
	endproperty
	a_byte_keep: assert property (p_byte_keep)
		else $error("byte write disturbed");

endmodule : gpr_bank

// ---- src/flag_compute.sv ----
`timescale 1ns/1ps
// arithmetic flag values from operands and result
module flag_compute
	import cpu_regs_pkg::*;
(
	input wire alu_kind_t kind, // operation class
	input wire logic is_word, // 1 word operation, 0 byte
	input wire logic [15:0] a, // destination operand
	input wire logic [15:0] b, // source operand
	input wire logic [15:0] res, // operation result
	input wire logic shift_out, // bit shifted out of the end
	input wire logic carry_in, // present carry flag
	output logic h, // half-carry
	output logic n, // negative
	output logic z, // zero
	output logic v, // overflow
	output logic c // carry or borrow
);
	logic [15:0] ea;
	logic [15:0] cy;
	logic [15:0] bw;
	logic sa;
	logic sb;
	logic sr;

	always_comb begin
		// negate is a subtraction from zero
		ea = (kind == ALU_NEG) ? 16'h0000 : a;
		cy = (ea & b) | ((ea | b) & ~res);
		bw = (~ea & b) | ((~ea | b) & res);
		sa = is_word ? ea[MSB_WORD] : ea[MSB_BYTE];
		sb = is_word ? b[MSB_WORD] : b[MSB_BYTE];
		sr = is_word ? res[MSB_WORD] : res[MSB_BYTE];
		n = sr;
		z = is_word ? (res == 16'h0000) : (res[7:0] == 8'h00);
		h = 1'b0;
		v = 1'b0;
		c = carry_in;
		unique case (kind)
			ALU_ADD: begin
				h = is_word ? cy[HC_BIT_WORD] : cy[HC_BIT_BYTE];
				c = is_word ? cy[MSB_WORD] : cy[MSB_BYTE];
				v = (sa == sb) && (sr != sa);
			end
			ALU_SUB, ALU_NEG: begin
				h = is_word ? bw[HC_BIT_WORD] : bw[HC_BIT_BYTE];
				c = is_word ? bw[MSB_WORD] : bw[MSB_BYTE];
				v = (sa != sb) && (sr != sa);
			end
			ALU_LOGIC: begin
				v = 1'b0;
			end
			ALU_SHIFT: begin
				c = shift_out;
			end
			default: begin
				c = carry_in;
			end
		endcase
	end

endmodule : flag_compute

// ---- src/cpu_regfile.sv ----
// programmer-visible cpu registers: general registers, pc and flags
//
// Notes on behaviour
// - sixteen byte registers also pair as eight word registers
// - data access by word, upper byte or lower byte
// - address reads always return the full word
// - eighth word register is the stack pointer, top of stack
// - pc holds next instruction address, bit 0 always zero
// - flags readable and writable by the flag transfer instructions
// - negative, zero, overflow, carry feed the branch decision
// - flag bit 7 set masks interrupts, software reads and writes it
// - exception start sets the interrupt mask bit
// - flag bits 6 and 4 are free user storage
// - byte add/sub/cmp/neg half-carry is the carry at bit 3
// - word add/sub/cmp half-carry is the carry at bit 11
// - decimal adjust logic reads half-carry implicitly
// - negative takes the result sign bit
// - zero set on zero result, cleared otherwise
// - overflow set on arithmetic overflow, cleared otherwise
// - carry holds add carry, subtract borrow, or shifted-out bit
// - carry is the one-bit accumulator for bit instructions
// - per-instruction mask leaves chosen flags unchanged
// - reset loads pc from vector at address zero, sets mask
// - reset leaves general registers and other flags undefined
`timescale 1ns/1ps
module cpu_regfile
	import cpu_regs_pkg::*;
(
	input wire logic core_clk, // cpu clock, 100 MHz
	input wire logic nrst, // asynchronous reset, active low
	output logic vec_req, // reset vector read request
	output logic [15:0] vec_addr, // reset vector address
	input wire logic vec_valid, // vector data valid
	input wire logic [15:0] vec_data, // reset vector contents
	output logic core_ready, // vector loaded, requests accepted
	input wire logic wr_en, // general register write strobe
	input wire logic wr_word, // 1 word write, 0 byte write
	input wire logic [3:0] wr_idx, // [2:0] register, [3] lower byte
	input wire logic [15:0] wr_data, // write data
	input wire logic [2:0] word_a_idx, // word data read select
	output logic [15:0] word_a, // word data read value
	input wire logic [3:0] byte_idx, // byte read select
	output logic [7:0] byte_val, // byte read value
	input wire logic [2:0] addr_idx, // address register select
	output logic [15:0] addr_word, // address register value
	output logic [15:0] stack_pointer, // stack pointer value
	input wire logic pc_load, // load pc from pc_target
	input wire logic [15:0] pc_target, // branch or jump target
	input wire logic pc_advance, // step pc by one word
	output logic [15:0] program_counter, // next instruction address
	input wire logic alu_upd, // flag update from an operation
	input wire alu_kind_t alu_kind, // operation class
	input wire logic alu_word, // 1 word operation
	input wire logic [15:0] alu_a, // destination operand
	input wire logic [15:0] alu_b, // source operand
	input wire logic [15:0] alu_res, // operation result
	input wire logic alu_shift_out, // bit shifted out
	input wire logic [7:0] flag_keep_mask, // 1 keeps that flag
	input wire logic flag_instr, // flag transfer or logic instruction
	input wire flag_op_t flag_op, // load, and, or, xor
	input wire logic [7:0] flag_imm, // operand for flag_op
	input wire logic bit_c_wr, // bit instruction writes carry
	input wire logic bit_c_val, // value for carry
	input wire logic exception_start, // exception handling begins
	output logic [7:0] condition_flags, // flag register
	output logic int_masked, // interrupts masked
	output logic half_carry, // half-carry for decimal adjust
	output logic [3:0] cond_nzvc, // branch condition flags
	input wire branch_cond_t branch_cond, // condition under test
	output logic branch_taken // condition holds
);
	typedef enum logic {
		ST_FETCH_VEC,
		ST_RUN
	} boot_state_t;

	boot_state_t state;
	logic mask_i;
	logic [6:0] flag_low;
	logic [7:0] next_flags;
	logic [7:0] alu_flags;
	logic [14:0] pc_word;
	logic fh;
	logic fn;
	logic fz;
	logic fv;
	logic fc;

	gpr_bank u_gpr (
		.core_clk(core_clk),
		.nrst(nrst),
		.wr_en(wr_en && core_ready),
		.wr_word(wr_word),
		.wr_idx(wr_idx),
		.wr_data(wr_data),
		.word_a_idx(word_a_idx),
		.word_a(word_a),
		.byte_idx(byte_idx),
		.byte_val(byte_val),
		.addr_idx(addr_idx),
		.addr_word(addr_word),
		.stack_pointer(stack_pointer)
	);

	flag_compute u_flags (
		.kind(alu_kind),
		.is_word(alu_word),
		.a(alu_a),
		.b(alu_b),
		.res(alu_res),
		.shift_out(alu_shift_out),
		.carry_in(condition_flags[FLAG_C]),
		.h(fh),
		.n(fn),
		.z(fz),
		.v(fv),
		.c(fc)
	);

	// boot: the pc is not usable until the vector word has arrived
	always_ff @(posedge core_clk or negedge nrst) begin
		if (!nrst) begin
			state <= ST_FETCH_VEC;
		end else if (state == ST_FETCH_VEC && vec_valid) begin
			state <= ST_RUN;
		end
	end

	assign vec_req = (state == ST_FETCH_VEC);
	assign vec_addr = RESET_VECTOR_ADDR;
	assign core_ready = (state == ST_RUN);

	always_ff @(posedge core_clk or negedge nrst) begin
		if (!nrst) begin
			pc_word <= PC_WORD_RESET;
		end else if (state == ST_FETCH_VEC) begin
			if (vec_valid)
				pc_word <= vec_data[15:1];
		end else if (pc_load) begin
			pc_word <= pc_target[15:1];
		end else if (pc_advance) begin
			pc_word <= pc_word + 15'h0001;
		end
	end

	assign program_counter = {pc_word, 1'b0};

	// the alu never touches mask or user bits, whatever the keep mask says
	assign alu_flags = {condition_flags[FLAG_I], condition_flags[FLAG_U1],
		fh, condition_flags[FLAG_U0], fn, fz, fv, fc};

	// priority: flag instruction, then bit accumulator, then alu,
	// and an exception's mask set overrides everything
	always_comb begin
		next_flags = condition_flags;
		if (core_ready) begin
			if (alu_upd)
				next_flags = (condition_flags & flag_keep_mask)
					| (alu_flags & ~flag_keep_mask);
			if (bit_c_wr)
				next_flags[FLAG_C] = bit_c_val;
			if (flag_instr) begin
				unique case (flag_op)
					FOP_LOAD: next_flags = flag_imm;
					FOP_AND: next_flags = condition_flags & flag_imm;
					FOP_OR: next_flags = condition_flags | flag_imm;
					FOP_XOR: next_flags = condition_flags ^ flag_imm;
				endcase
			end
			if (exception_start)
				next_flags[FLAG_I] = 1'b1;
		end
	end

	always_ff @(posedge core_clk or negedge nrst) begin
		if (!nrst)
			mask_i <= FLAG_I_RESET;
		else
			mask_i <= next_flags[FLAG_I];
	end

	// no reset on the other flags, so they start undefined
	always_ff @(posedge core_clk) begin
		flag_low <= next_flags[6:0];
	end

	assign condition_flags = {mask_i, flag_low};
	assign int_masked = mask_i;
	assign half_carry = condition_flags[FLAG_H];
	assign cond_nzvc = condition_flags[3:0];

	function automatic logic cond_met(input branch_cond_t cc,
		input logic [3:0] f);
		logic n;
		logic z;
		logic v;
		logic c;
		n = f[FLAG_N];
		z = f[FLAG_Z];
		v = f[FLAG_V];
		c = f[FLAG_C];
		unique case (cc)
			COND_ALWAYS: cond_met = 1'b1;
			COND_NEVER: cond_met = 1'b0;
			COND_HI: cond_met = !(c || z);
			COND_LS: cond_met = c || z;
			COND_CC: cond_met = !c;
			COND_CS: cond_met = c;
			COND_NE: cond_met = !z;
			COND_EQ: cond_met = z;
			COND_VC: cond_met = !v;
			COND_VS: cond_met = v;
			COND_PL: cond_met = !n;
			COND_MI: cond_met = n;
			COND_GE: cond_met = !(n ^ v);
			COND_LT: cond_met = n ^ v;
			COND_GT: cond_met = !(z || (n ^ v));
			COND_LE: cond_met = z || (n ^ v);
		endcase
	endfunction : cond_met

	assign branch_taken = cond_met(branch_cond, cond_nzvc);

	property p_vec_load;
		@(posedge core_clk) disable iff (!nrst)
		(vec_req && vec_valid) |=>
			program_counter == {$past(vec_data[15:1]), 1'b0} && core_ready;
	endproperty
	a_vec_load: assert property (p_vec_load)
		else $error("vector not loaded");

	property p_boot_masked;
		@(posedge core_clk) disable iff (!nrst)
		!core_ready |-> int_masked && vec_req;
	endproperty
	a_boot_masked: assert property (p_boot_masked)
		else $error("mask clear in boot");

	property p_pc_load;
		@(posedge core_clk) disable iff (!nrst)
		(core_ready && pc_load) |=>
			program_counter == {$past(pc_target[15:1]), 1'b0};
	endproperty
	a_pc_load: assert property (p_pc_load)
		else $error("pc load wrong");

	property p_pc_step;
		@(posedge core_clk) disable iff (!nrst)
		(core_ready && !pc_load && pc_advance) |=>
			program_counter == $past(program_counter) + 16'h0002;
	endproperty
	a_pc_step: assert property (p_pc_step)
		else $error("pc step wrong");

	property p_exc_mask;
		@(posedge core_clk) disable iff (!nrst)
		(core_ready && exception_start) |=> int_masked;
	endproperty
	a_exc_mask: assert property (p_exc_mask)
		else $error("mask not set");

	property p_flag_load;
		@(posedge core_clk) disable iff (!nrst)
		(core_ready && flag_instr && flag_op == FOP_LOAD && !exception_start)
			|=> condition_flags == $past(flag_imm);
	endproperty
	a_flag_load: assert property (p_flag_load)
		else $error("flag load wrong");

	property p_keep;
		@(posedge core_clk) disable iff (!nrst)
		(core_ready && alu_upd && !flag_instr && !bit_c_wr &&
			!exception_start) |=>
			((condition_flags ^ $past(condition_flags)) &
			$past(flag_keep_mask)) == 8'h00;
	endproperty
	a_keep: assert property (p_keep)
		else $error("kept flag changed");

	property p_bit_acc;
		@(posedge core_clk) disable iff (!nrst)
		(core_ready && bit_c_wr && !flag_instr) |=>
			condition_flags[FLAG_C] == $past(bit_c_val);
	endproperty
	a_bit_acc: assert property (p_bit_acc)
		else $error("carry not written");

	property p_half_byte;
		@(posedge core_clk) disable iff (!nrst)
		(core_ready && alu_upd && alu_kind == ALU_ADD && !alu_word &&
			!flag_keep_mask[FLAG_H] && !flag_instr) |=>
			condition_flags[FLAG_H] ==
			$past(alu_a[4] ^ alu_b[4] ^ alu_res[4]);
	endproperty
	a_half_byte: assert property (p_half_byte)
		else $error("half-carry wrong");

	property p_zero;
		@(posedge core_clk) disable iff (!nrst)
		(core_ready && alu_upd && alu_word && !flag_keep_mask[FLAG_Z] &&
			!flag_instr) |=>
			condition_flags[FLAG_Z] == ($past(alu_res) == 16'h0000);
	endproperty
	a_zero: assert property (p_zero)
		else $error("zero flag wrong");

	property p_branch_ge;
		@(posedge core_clk) disable iff (!nrst)
		(branch_cond == COND_GE) |->
			branch_taken == (condition_flags[FLAG_N] == condition_flags[FLAG_V]);
	endproperty
	a_branch_ge: assert property (p_branch_ge)
		else $error("branch wrong");

endmodule : cpu_regfile

// ---- bench/vec_mem.sv ----
// reset vector memory answering the register file's vector fetch
`timescale 1ns/1ps
module vec_mem #(
	parameter logic [15:0] VECTOR = 16'h1235, // odd on purpose, lsb must drop
	parameter int DELAY = 2 // wait states before the answer
) (
	input wire logic core_clk, // cpu clock
	input wire logic nrst, // asynchronous reset, active low
	input wire logic vec_req, // vector read request
	input wire logic [15:0] vec_addr, // vector address
	output logic vec_valid, // vector data valid, one cycle
	output logic [15:0] vec_data // vector contents
);
	int cnt;

	always_ff @(posedge core_clk or negedge nrst) begin
		if (!nrst) begin
			cnt <= 0;
			vec_valid <= 1'b0;
		end else if (vec_req && !vec_valid) begin
			if (cnt == DELAY) begin
				vec_valid <= 1'b1;
			end else begin
				cnt <= cnt + 1;
			end
		end else begin
			vec_valid <= 1'b0;
			cnt <= 0;
		end
	end

	// only address zero holds the vector; idle data is inverted, not stale
	assign vec_data = (vec_valid && vec_addr == 16'h0000) ? VECTOR : ~VECTOR;
endmodule : vec_mem

// ---- bench/tb_cpu_register_file_and_flags.sv ----
// self-checking bench for the cpu register set
`timescale 1ns/1ps
module tb_cpu_register_file_and_flags
	import cpu_regs_pkg::*;
;
	logic core_clk, nrst, vec_req, vec_valid, core_ready;
	logic [15:0] vec_addr, vec_data;
	logic wr_en, wr_word;
	logic [3:0] wr_idx, byte_idx, cond_nzvc;
	logic [15:0] wr_data, word_a, addr_word, stack_pointer;
	logic [2:0] word_a_idx, addr_idx;
	logic [7:0] byte_val, flag_keep_mask, flag_imm, condition_flags;
	logic pc_load, pc_advance, alu_upd, alu_word, alu_shift_out;
	logic [15:0] pc_target, program_counter, alu_a, alu_b, alu_res;
	alu_kind_t alu_kind;
	flag_op_t flag_op;
	branch_cond_t branch_cond;
	logic flag_instr, bit_c_wr, bit_c_val, exception_start;
	logic int_masked, half_carry, branch_taken;
	int n_errors = 0;
	int num_checks = 0;
	int cycles = 0;

	cpu_regfile DUT (.core_clk, .nrst, .vec_req, .vec_addr, .vec_valid,
		.vec_data, .core_ready, .wr_en, .wr_word, .wr_idx, .wr_data,
		.word_a_idx, .word_a, .byte_idx, .byte_val, .addr_idx, .addr_word,
		.stack_pointer, .pc_load, .pc_target, .pc_advance, .program_counter,
		.alu_upd, .alu_kind, .alu_word, .alu_a, .alu_b, .alu_res,
		.alu_shift_out, .flag_keep_mask, .flag_instr, .flag_op, .flag_imm,
		.bit_c_wr, .bit_c_val, .exception_start, .condition_flags,
		.int_masked, .half_carry, .cond_nzvc, .branch_cond, .branch_taken);

	vec_mem #(.VECTOR(16'h1235), .DELAY(2)) mem (.core_clk, .nrst, .vec_req,
		.vec_addr, .vec_valid, .vec_data);

	always #5 core_clk = ~core_clk;

	// whole run needs well under a thousand cycles
	always @(posedge core_clk) begin
		cycles++;
		if (cycles == 4000) begin
			n_errors++;
			$display("wrong value at %0t: run hung", $time);
			stop_test();
		end
	end

	task stop_test;
		$display("checks %0d mismatches %0d", num_checks, n_errors);
		if (n_errors == 0 && num_checks > 0)
			$display("Run complete: PASS");
		else
			$display("Run complete: FAIL");
		$finish;
	endtask : stop_test

	task chk(input logic [15:0] got, input logic [15:0] exp, input string m);
		num_checks++;
		if (got !== exp) begin
			n_errors++;
			$display("wrong value at %0t: %s got %h exp %h", $time, m, got, exp);
		end
	endtask : chk

	// one strobe for one cycle: 0 write, 1 load, 2 step, 3 alu, 4 flag op,
	// 5 carry write, 6 exception
	task go(input int s, input logic [15:0] v, input logic w,
		input logic [3:0] x);
		@(posedge core_clk);
		wr_data <= v;
		wr_word <= w;
		wr_idx <= x;
		pc_target <= v;
		bit_c_val <= v[0];
		flag_imm <= v[7:0];
		flag_op <= flag_op_t'(x[1:0]);
		wr_en <= (s == 0);
		pc_load <= (s == 1);
		pc_advance <= (s == 2);
		alu_upd <= (s == 3);
		flag_instr <= (s == 4);
		bit_c_wr <= (s == 5);
		exception_start <= (s == 6);
		@(posedge core_clk);
		{wr_en, pc_load, pc_advance, alu_upd} <= '0;
		{flag_instr, bit_c_wr, exception_start} <= '0;
		#1;
	endtask : go

	task alu(input alu_kind_t k, input logic w, input logic [15:0] a, b, r,
		input logic so, input logic [7:0] m, e);
		@(posedge core_clk);
		alu_kind <= k;
		alu_word <= w;
		alu_a <= a;
		alu_b <= b;
		alu_res <= r;
		alu_shift_out <= so;
		flag_keep_mask <= m;
		go(3, 16'h0000, 1'b0, 4'h0);
		chk(condition_flags, e, "flags");
		chk(half_carry, e[5], "half carry");
		chk(cond_nzvc, e[3:0], "nzvc");
	endtask : alu

	task boot;
		int i;
		for (i = 0; i < 20 && core_ready !== 1'b1; i++)
			@(posedge core_clk);
		#1;
		chk(core_ready, 1'b1, "ready");
		chk(vec_addr, 16'h0000, "vector address");
		chk(program_counter, 16'h1234, "pc from vector");
		chk(int_masked, 1'b1, "mask after reset");
		chk(vec_req, 1'b0, "request dropped");
	endtask : boot

	function automatic logic bexp(input int c, input logic [3:0] f);
		logic n, z, v, cy, b;
		{n, z, v, cy} = f;
		case (c / 2)
			0: b = 1'b1;
			1: b = !cy && !z;
			2: b = !cy;
			3: b = !z;
			4: b = !v;
			5: b = !n;
			6: b = (n == v);
			default: b = !z && (n == v);
		endcase
		return (c % 2) ? !b : b;
	endfunction : bexp

	initial begin
		core_clk = 0;
		nrst = 0;
		{wr_en, wr_word, pc_load, pc_advance, alu_upd, alu_word} = '0;
		{alu_shift_out, flag_instr, bit_c_wr, bit_c_val, exception_start} = '0;
		{wr_idx, byte_idx, word_a_idx, addr_idx} = '0;
		{wr_data, pc_target, alu_a, alu_b, alu_res} = '0;
		{flag_keep_mask, flag_imm} = '0;
		alu_kind = ALU_ADD;
		flag_op = FOP_LOAD;
		branch_cond = COND_ALWAYS;
		repeat (4) @(posedge core_clk);
		nrst <= 1'b1;
		boot();
		$display("test boot done");

		go(0, 16'hF00D, 1'b1, 4'h7);
		chk(stack_pointer, 16'hF00D, "stack pointer");
		for (int i = 0; i < 8; i++)
			go(0, 16'h3C5A ^ (16'h1111 * i[15:0]), 1'b1, i[3:0]);
		for (int i = 0; i < 8; i++) begin
			@(posedge core_clk);
			word_a_idx <= i[2:0];
			addr_idx <= i[2:0];
			byte_idx <= {1'b0, i[2:0]};
			#1;
			chk(word_a, 16'h3C5A ^ (16'h1111 * i[15:0]), "word");
			chk(addr_word, 16'h3C5A ^ (16'h1111 * i[15:0]), "addr");
			chk(byte_val, 8'h3C ^ (8'h11 * i[7:0]), "upper");
		end
		chk(stack_pointer, 16'h3C5A ^ 16'h7777, "sp is reg 7");
		go(0, 16'h00AB, 1'b0, 4'b1010);
		@(posedge core_clk);
		word_a_idx <= 3'h2;
		#1;
		chk(word_a, 16'h1EAB, "upper kept");
		go(0, 16'h00CD, 1'b0, 4'b0010);
		@(posedge core_clk);
		word_a_idx <= 3'h2;
		byte_idx <= 4'b1010;
		addr_idx <= 3'h3;
		#1;
		chk(word_a, 16'hCDAB, "byte halves");
		chk(byte_val, 8'hAB, "lower");
		chk(addr_word, 16'h3C5A ^ 16'h3333, "neighbour");
		$display("test registers done");

		go(1, 16'h2345, 1'b0, 4'h0);
		chk(program_counter, 16'h2344, "pc load");
		go(2, 16'h0000, 1'b0, 4'h0);
		chk(program_counter, 16'h2346, "pc step");
		$display("test pc done");

		go(4, 16'h0000, 1'b0, FOP_LOAD);
		chk(condition_flags, 8'h00, "load");
		chk(int_masked, 1'b0, "unmasked");
		go(4, 16'h0050, 1'b0, FOP_OR);
		chk(condition_flags, 8'h50, "or user bits");
		go(4, 16'h0041, 1'b0, FOP_XOR);
		chk(condition_flags, 8'h11, "xor");
		go(4, 16'h001F, 1'b0, FOP_AND);
		chk(condition_flags, 8'h11, "and");
		go(6, 16'h0000, 1'b0, 4'h0);
		chk(condition_flags, 8'h91, "exception");
		chk(int_masked, 1'b1, "masked");
		go(4, 16'h0050, 1'b0, FOP_LOAD);
		alu(ALU_ADD, 0, 16'h0F, 16'h01, 16'h10, 0, 8'h00, 8'h70);
		alu(ALU_ADD, 1, 16'h0FFF, 16'h1, 16'h1000, 0, 8'h00, 8'h70);
		alu(ALU_SUB, 0, 16'h00, 16'h01, 16'hFF, 0, 8'h00, 8'h79);
		alu(ALU_ADD, 0, 16'h7F, 16'h01, 16'h80, 0, 8'h00, 8'h7A);
		alu(ALU_ADD, 0, 16'hFF, 16'h01, 16'h00, 0, 8'h00, 8'h75);
		alu(ALU_NEG, 0, 16'h00, 16'h01, 16'hFF, 0, 8'h00, 8'h79);
		alu(ALU_SHIFT, 0, 16'h80, 16'h0, 16'h00, 1, 8'h00, 8'h55);
		alu(ALU_LOGIC, 0, 16'h0F, 16'hF0, 16'hFF, 0, 8'h00, 8'h59);
		alu(ALU_ADD, 0, 16'h00, 16'h00, 16'h00, 1, 8'hFF, 8'h59);
		alu(ALU_SUB, 1, 16'h1000, 16'h1, 16'h0FFF, 0, 8'h00, 8'h70);
		go(5, 16'h0001, 1'b0, 4'h0);
		chk(condition_flags, 8'h71, "bit carry set");
		go(5, 16'h0000, 1'b0, 4'h0);
		chk(condition_flags, 8'h70, "bit carry clear");
		$display("test flags done");

		for (int f = 0; f < 16; f++) begin
			go(4, {12'h000, f[3:0]}, 1'b0, FOP_LOAD);
			for (int c = 0; c < 16; c++) begin
				@(posedge core_clk);
				branch_cond <= branch_cond_t'(c[3:0]);
				#1;
				chk(branch_taken, bexp(c, f[3:0]), "branch");
			end
		end
		$display("test branch done");

		go(4, 16'h0000, 1'b0, FOP_LOAD);
		@(posedge core_clk);
		nrst <= 1'b0;
		@(posedge core_clk);
		#1;
		chk(int_masked, 1'b1, "mask in reset");
		chk(vec_req, 1'b1, "request in reset");
		chk(core_ready, 1'b0, "not ready in reset");
		@(posedge core_clk);
		nrst <= 1'b1;
		// this write lands while the vector is still awaited, so it must drop
		go(0, 16'hDEAD, 1'b1, 4'h1);
		boot();
		@(posedge core_clk);
		word_a_idx <= 3'h1;
		#1;
		chk(word_a, 16'h2D4B, "write in boot ignored");
		$display("test second reset done");
		stop_test();
	end
endmodule : tb_cpu_register_file_and_flags
